// File: verif/rlm_coil_model.sv
`timescale 1ns/1ps
// Relay coils and lamps seen as loads on the output pins
module rlm_coil_model (
   // Drives from the block
   input  wire logic [5:0]  relay_drive,
   input  wire logic [7:0]  lamp_drive,
   // Load state for the bench
   output      logic [13:0] energised
);
   // Loads hold no state: a dropped drive releases the coil at once, so a
   // glitch on a drive shows straight through to the bench
   assign energised = {lamp_drive, relay_drive};
endmodule // rlm_coil_model

// File: verif/rlm_top_asserts.sv
`timescale 1ns/1ps
// Output checker, watching the top ports only
module rlm_chk #(
   parameter bit HAS_DISPLAY = 1'b0
) (
   // Clock and reset
   input wire logic                           clk,
   input wire logic                           rstn,
   // Bus
   input wire rlm_pkg::rlm_apb_req_s          apb_req,
   input wire rlm_pkg::rlm_apb_rsp_s          apb_rsp,
   // Evaluation inputs
   input wire logic                           eval_tick,
   input wire logic [rlm_pkg::N_PROG_RLY-1:0] relay_lgc,
   input wire logic [rlm_pkg::N_LAMP-1:0]     lamp_lgc,
   input wire logic [rlm_pkg::N_FLAG-1:0]     flag_ladder,
   input wire rlm_pkg::rlm_cond_s             cond,
   input wire logic                           not_ready,
   input wire logic                           controlled_breaker_open,
   input wire logic                           controlled_breaker_close,
   // Outputs
   input wire logic                           relay_out_one,
   input wire logic                           relay_out_two,
   input wire logic                           relay_out_three,
   input wire logic                           relay_out_four,
   input wire logic                           relay_out_five,
   input wire logic                           relay_out_six,
   input wire logic [rlm_pkg::N_LAMP-1:0]     lamp_out,
   input wire logic [rlm_pkg::N_FLAG-1:0]     flag_q,
   input wire logic [rlm_pkg::N_PROG_RLY-1:0] cmd_var_q
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   // All registered outputs in one word
   logic [34:0] outs;
   assign outs = {relay_out_six, relay_out_five, relay_out_four, relay_out_three,
                  relay_out_two, relay_out_one, lamp_out, flag_q, cmd_var_q};
   // Breaker mode as last written over the bus
   logic mode_q;
   always_ff @(posedge clk or negedge rstn)
      if (!rstn) mode_q <= 1'b0;
      else if (apb_req.psel && apb_req.penable && apb_req.pwrite && apb_rsp.pready
               && apb_req.paddr == rlm_pkg::OFS_CTRL)
         mode_q <= apb_req.pwdata[rlm_pkg::CTRL_TWO_RELAY_POS];
   // ****************************************
   // Assertions
   // ****************************************
   chk_reset_idle: assert property ($rose(rstn) |-> outs == 35'h0_0000_0000)
      else $error("outputs not idle after reset");
   chk_hold_no_tick: assert property (!eval_tick |=> $stable(outs))
      else $error("outputs moved without a tick");
   chk_open_relay: assert property (eval_tick |=>
      relay_out_five == $past(controlled_breaker_open))
      else $error("relay five does not follow open command");
   chk_relay_one: assert property (eval_tick |=>
      relay_out_one == (cmd_var_q[0] | $past(not_ready)))
      else $error("relay one not result or not ready");
   chk_relay_cmd: assert property (eval_tick |=>
      {relay_out_four, relay_out_three, relay_out_two} == cmd_var_q[3:1])
      else $error("relays two to four differ from results");
   chk_relay_six: assert property (eval_tick |=>
      relay_out_six == ($past(mode_q) ? $past(controlled_breaker_close) : cmd_var_q[4]))
      else $error("relay six from no legal source");
   chk_flag_latch: assert property (eval_tick |=> flag_q == $past(flag_ladder))
      else $error("flags not latched from ladder");
   chk_lamp_absent: assert property (HAS_DISPLAY |-> lamp_out == 8'h00)
      else $error("lamps driven on display variant");
   chk_pready_pulse: assert property (apb_req.psel && !apb_req.penable |=>
      apb_rsp.pready ##1 !apb_rsp.pready)
      else $error("pready not a single pulse after setup");
endmodule // rlm_chk

bind rlm_top rlm_chk #(.HAS_DISPLAY(HAS_DISPLAY)) u_rlm_chk (
   .clk(clk), .rstn(rstn), .apb_req(apb_req), .apb_rsp(apb_rsp), .eval_tick(eval_tick),
   .relay_lgc(relay_lgc), .lamp_lgc(lamp_lgc), .flag_ladder(flag_ladder), .cond(cond),
   .not_ready(not_ready), .controlled_breaker_open(controlled_breaker_open),
   .controlled_breaker_close(controlled_breaker_close), .relay_out_one(relay_out_one),
   .relay_out_two(relay_out_two), .relay_out_three(relay_out_three),
   .relay_out_four(relay_out_four), .relay_out_five(relay_out_five),
   .relay_out_six(relay_out_six), .lamp_out(lamp_out), .flag_q(flag_q), .cmd_var_q(cmd_var_q));

// File: verif/testbench.sv
`timescale 1ns/1ps
module testbench;
   // ****************************************
   // Signals
   // ****************************************
   logic                  clk, rstn, tk, nr, bo, bc, tr, er;
   rlm_pkg::rlm_apb_req_s req;
   rlm_pkg::rlm_apb_rsp_s rsp, rsp2;
   rlm_pkg::rlm_cond_s    cnd;
   logic [4:0]            rl, cv_q, cv2;
   logic [7:0]            ll, lo, lo2;
   logic [5:0]            ro, ro2;
   logic [15:0]           fl, fq, fq2, ls;
   logic [9:0]            rs;
   logic [13:0]           coil;
   logic [18:0]           exp_q;
   logic [31:0]           rd;
   logic [31:0]           pat [4] = '{32'hA5C3_5A3C, 32'h3C96_C369, 32'hF00F_0FF0, 32'h6A59_95A6};
   int                    err_total, checks;

   // Lamp variant, checked end to end, and display variant beside it
   rlm_top #(.HAS_DISPLAY(1'b0)) DUT (
      .clk(clk), .rstn(rstn), .apb_req(req), .apb_rsp(rsp), .eval_tick(tk),
      .relay_lgc(rl), .lamp_lgc(ll), .flag_ladder(fl), .cond(cnd), .not_ready(nr),
      .controlled_breaker_open(bo), .controlled_breaker_close(bc),
      .relay_out_one(ro[0]), .relay_out_two(ro[1]), .relay_out_three(ro[2]),
      .relay_out_four(ro[3]), .relay_out_five(ro[4]), .relay_out_six(ro[5]),
      .lamp_out(lo), .flag_q(fq), .cmd_var_q(cv_q));
   rlm_top #(.HAS_DISPLAY(1'b1)) DUT_DISP (
      .clk(clk), .rstn(rstn), .apb_req(req), .apb_rsp(rsp2), .eval_tick(tk),
      .relay_lgc(rl), .lamp_lgc(ll), .flag_ladder(fl), .cond(cnd), .not_ready(nr),
      .controlled_breaker_open(bo), .controlled_breaker_close(bc),
      .relay_out_one(ro2[0]), .relay_out_two(ro2[1]), .relay_out_three(ro2[2]),
      .relay_out_four(ro2[3]), .relay_out_five(ro2[4]), .relay_out_six(ro2[5]),
      .lamp_out(lo2), .flag_q(fq2), .cmd_var_q(cv2));
   rlm_coil_model COILS (.relay_drive(ro), .lamp_drive(lo), .energised(coil));

   // ****************************************
   // Reference model and tasks
   // ****************************************
   function automatic logic pick(logic [1:0] s, logic d, logic l);
      case (s)
         rlm_pkg::SRC_DEFAULT: return d;
         rlm_pkg::SRC_LOGIC:   return l;
         rlm_pkg::SRC_OFF:     return 1'b0;
         default:              return 1'b1;
      endcase
   endfunction

   // Returns {command results, lamps, relays}; pattern bits map as driven in tick
   function automatic logic [18:0] model(logic [9:0] s, logic [15:0] t, logic m,
                                         logic [31:0] pv);
      rlm_pkg::rlm_cond_s c;
      logic [4:0] d, cv;
      logic [7:0] ld, lm;
      c = pv[24:13];
      d = {c.all_alarm_class, c.sys_a_not_ok, c.sys_b_not_ok, c.central_alarm, 1'b0};
      ld = {c.member_missing, c.close_failure, c.open_failure, c.close_cmd_active,
            c.sync_active, c.breaker_closed, c.sys_b_in_range, c.sys_a_in_range};
      for (int i = 0; i < 5; i++) cv[i] = pick(s[2*i +: 2], d[i], pv[i]);
      for (int i = 0; i < 8; i++) lm[i] = pick(t[2*i +: 2], ld[i], pv[5+i]);
      return {cv, lm, m ? pv[27] : cv[4], pv[26], cv[3:1], cv[0] | pv[25]};
   endfunction

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
      checks++;
      if (seen !== ex) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", nm, ex, seen);
      end
   endtask

   // One APB transfer; waits for pready as long as it takes, the watchdog ends a hang
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int n;
      @(posedge clk);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
      @(posedge clk);
      req.penable <= 1'b1;
      @(posedge clk);
      while (rsp.pready !== 1'b1) begin
         n++;
         @(posedge clk);
      end
      chk("wait_states", 32'(n), 32'h0000_0000);
      rd = rsp.prdata;
      er = rsp.pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask

   task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] ex,
                       input logic e);
      apb(1'b0, a, 32'h0000_0000);
      chk(nm, rd, ex);
      chk("slverr", 32'(er), 32'(e));
   endtask

   // Checks outputs held since last tick, then ticks once with a new pattern
   task automatic tick(input logic [31:0] pv);
      @(negedge clk);
      chk("held", 32'({cv_q, coil}), 32'(exp_q));
      @(posedge clk);
      {bc, bo, nr, cnd, ll, rl} <= pv[27:0];
      fl <= pv[31:16];
      tk <= 1'b1;
      exp_q = model(rs, ls, tr, pv);
      @(posedge clk);
      tk <= 1'b0;
      @(negedge clk);
      chk("relays", 32'(coil[5:0]), 32'(exp_q[5:0]));
      chk("lamps", 32'(coil[13:6]), 32'(exp_q[13:6]));
      chk("cmd_var", 32'(cv_q), 32'(exp_q[18:14]));
      chk("flags", 32'(fq), 32'(pv[31:16]));
      chk("lamps_disp", 32'(lo2), 32'h0000_0000);
   endtask

   task automatic print_verdict;
      $display("checks %0d errors %0d", checks, err_total);
      if (err_total == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   // ****************************************
   // Clock, watchdog and sequence
   // ****************************************
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // Run needs well under 4000 cycles; a hang is cut there
   initial begin
      #200_000;
      err_total++;
      print_verdict;
   end

   initial begin
      rstn = 1'b0;
      tk = 1'b0;
      req = '0;
      {bc, bo, nr, cnd, ll, rl} = '0;
      {fl, rs, ls, tr, exp_q} = '0;
      err_total = 0;
      checks = 0;
      repeat (4) @(posedge clk);
      @(negedge clk);
      chk("reset_out", 32'({cv_q, coil}), 32'h0000_0000);
      @(posedge clk);
      rstn <= 1'b1;
      rchk("ctrl_rst", rlm_pkg::OFS_CTRL, rlm_pkg::RST_CTRL, 1'b0);
      rchk("rsel_rst", rlm_pkg::OFS_RELAY_SEL, rlm_pkg::RST_RELAY_SEL, 1'b0);
      rchk("lsel_rst", rlm_pkg::OFS_LAMP_SEL, rlm_pkg::RST_LAMP_SEL, 1'b0);
      rchk("unmapped", 8'h40, 32'h0000_0000, 1'b1);
      // Each channel walks through all four sources over the four passes
      for (int m = 0; m < 4; m++) begin
         for (int i = 0; i < 8; i++) begin
            if (i < 5) rs[2*i +: 2] = 2'(m + i);
            ls[2*i +: 2] = 2'(m + i);
         end
         tr = m[0];
         apb(1'b1, rlm_pkg::OFS_CTRL, 32'(tr));
         apb(1'b1, rlm_pkg::OFS_RELAY_SEL, 32'(rs));
         apb(1'b1, rlm_pkg::OFS_LAMP_SEL, 32'(ls));
         rchk("ctrl", rlm_pkg::OFS_CTRL, 32'(tr), 1'b0);
         rchk("relay_sel", rlm_pkg::OFS_RELAY_SEL, 32'(rs), 1'b0);
         rchk("lamp_sel", rlm_pkg::OFS_LAMP_SEL, 32'(ls), 1'b0);
         tick(pat[m]);
         tick(~pat[m]);
         apb(1'b1, rlm_pkg::OFS_OUT_STAT, 32'hFFFF_FFFF);
         rchk("stat", rlm_pkg::OFS_OUT_STAT, 32'({exp_q[13:6], 2'b00, exp_q[5:0]}), 1'b0);
         rchk("flags_reg", rlm_pkg::OFS_FLAGS, 32'(fl), 1'b0);
         rchk("cmd_reg", rlm_pkg::OFS_CMD_VAR, 32'(exp_q[18:14]), 1'b0);
      end
      tick(pat[0]);
      print_verdict;
   end
endmodule // testbench

// File: verilog/rlm_apb_slv.sv
`timescale 1ns/1ps
// APB slave handshake: one wait-free access phase per transfer
module rlm_apb_slv (
   // Clock and reset
   input  wire logic                          clk,
   input  wire logic                          rstn,
   // APB
   input  wire rlm_pkg::rlm_apb_req_s         apb_req,
   output      rlm_pkg::rlm_apb_rsp_s         apb_rsp,
   // Register bank side
   input  wire logic [rlm_pkg::DATA_W-1:0]    rd_data,
   input  wire logic                          hit,
   output      logic                          wr_stb
);

   typedef enum logic [0:0] {ST_IDLE, ST_ACCESS} rlm_st_e;

   rlm_st_e               st_q, st_d;
   rlm_pkg::rlm_apb_rsp_s rsp_q, rsp_d;

   // Write lands on the access edge where pready is sampled high
   assign wr_stb  = apb_req.psel & apb_req.penable & apb_req.pwrite & rsp_q.pready;
   assign apb_rsp = rsp_q;

   // Answer is prepared in the setup cycle so pready stands in the first access cycle
   always_comb begin
      st_d          = st_q;
      rsp_d         = rsp_q;
      rsp_d.pready  = 1'b0;
      case (st_q)
         ST_IDLE: begin
            if (apb_req.psel && !apb_req.penable) begin
               rsp_d.pready  = 1'b1;
               rsp_d.pslverr = ~hit;
               rsp_d.prdata  = (hit && !apb_req.pwrite) ? rd_data : '0;
               st_d          = ST_ACCESS;
            end
         end
         ST_ACCESS: begin
            rsp_d.pslverr = 1'b0;
            rsp_d.prdata  = '0;
            st_d          = ST_IDLE;
         end
         default: st_d = ST_IDLE;
      endcase
   end

   // Handshake registers
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st_q  <= ST_IDLE;
         rsp_q <= '0;
      end else begin
         st_q  <= st_d;
         rsp_q <= rsp_d;
      end
   end

endmodule // rlm_apb_slv

// File: verilog/rlm_pkg.sv
package rlm_pkg;

   // ****************************************************************
   // Bus geometry
   // ****************************************************************
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 32;

   // ****************************************************************
   // Register offsets (byte addresses)
   // ****************************************************************
   localparam logic [ADDR_W-1:0] OFS_CTRL      = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_RELAY_SEL = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_LAMP_SEL  = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_OUT_STAT  = 8'h0C;
   localparam logic [ADDR_W-1:0] OFS_FLAGS     = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_CMD_VAR   = 8'h14;

   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int unsigned CTRL_TWO_RELAY_POS = 0;   // Breaker driven by two relays
   localparam int unsigned STAT_RELAY_POS     = 0;   // Six relay states
   localparam int unsigned STAT_LAMP_POS      = 8;   // Eight lamp states
   localparam int unsigned SEL_W              = 2;   // Width of one source selector

   // ****************************************************************
   // Counts and reset values
   // ****************************************************************
   localparam int unsigned N_RELAY     = 6;
   localparam int unsigned N_PROG_RLY  = 5;          // Relays one to four and six
   localparam int unsigned N_LAMP      = 8;
   localparam int unsigned N_FLAG      = 16;
   localparam logic [DATA_W-1:0] RST_CTRL      = 32'h0000_0000;
   localparam logic [DATA_W-1:0] RST_RELAY_SEL = 32'h0000_0000;
   localparam logic [DATA_W-1:0] RST_LAMP_SEL  = 32'h0000_0000;

   // ****************************************************************
   // Types
   // ****************************************************************
   // Source of one programmable output
   typedef enum logic [SEL_W-1:0] {
      SRC_DEFAULT,
      SRC_LOGIC,
      SRC_OFF,
      SRC_ON
   } rlm_src_e;

   // APB request from the master
   typedef struct packed {
      logic              psel;
      logic              penable;
      logic              pwrite;
      logic [ADDR_W-1:0] paddr;
      logic [DATA_W-1:0] pwdata;
   } rlm_apb_req_s;

   // APB answer to the master
   typedef struct packed {
      logic              pready;
      logic              pslverr;
      logic [DATA_W-1:0] prdata;
   } rlm_apb_rsp_s;

   // Default conditions feeding the outputs
   typedef struct packed {
      logic central_alarm;     // Relay two
      logic sys_b_not_ok;      // Relay three
      logic sys_a_not_ok;      // Relay four
      logic all_alarm_class;   // Relay six
      logic sys_a_in_range;    // Lamp one
      logic sys_b_in_range;    // Lamp two
      logic breaker_closed;    // Lamp three
      logic sync_active;       // Lamp four
      logic close_cmd_active;  // Lamp five
      logic open_failure;      // Lamp six
      logic close_failure;     // Lamp seven
      logic member_missing;    // Lamp eight
   } rlm_cond_s;

endpackage

// File: verilog/rlm_src_mux.sv
`timescale 1ns/1ps
// Per-channel source selection between default, logic result and constants
module rlm_src_mux #(
   parameter int unsigned N = 8
) (
   // Selection
   input  wire logic [N*rlm_pkg::SEL_W-1:0] sel,
   // Sources
   input  wire logic [N-1:0]                dflt,
   input  wire logic [N-1:0]                lgc,
   // Result
   output      logic [N-1:0]                res
);

   // ****************************************************************
   // One selector per channel
   // ****************************************************************
   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_ch
         rlm_pkg::rlm_src_e s;
         assign s = rlm_pkg::rlm_src_e'(sel[g*rlm_pkg::SEL_W +: rlm_pkg::SEL_W]);
         // Constant codes let software force a coil for commissioning
         always_comb begin
            case (s)
               rlm_pkg::SRC_DEFAULT: res[g] = dflt[g];
               rlm_pkg::SRC_LOGIC:   res[g] = lgc[g];
               rlm_pkg::SRC_OFF:     res[g] = 1'b0;
               rlm_pkg::SRC_ON:      res[g] = 1'b1;
               default:              res[g] = 1'b0;
            endcase
         end
      end
   endgenerate

endmodule // rlm_src_mux

// File: verilog/rlm_top.sv
//
// Contract
// [RQ1] Relay one is on when its logic result or the not-ready status is true.
// [RQ2] Relay two follows its logic result, defaulting to the centralized alarm.
// [RQ3] Relay three follows its logic result, defaulting to system B not OK.
// [RQ4] Relay four follows its logic result, defaulting to system A not OK.
// [RQ5] Relay five is the open command; relay six closes in two-relay mode.
// [RQ6] Lamps exist only without display; each follows its own logic result.
// [RQ7] Lamps one and two default to system A and system B in range.
// [RQ8] Lamps three to five default to closed, synchronising, close command.
// [RQ9] Lamps six and seven default to open and close failure.
// [RQ10] Lamp eight defaults to the missing-member communication trip.
// [RQ11] Sixteen flags hold ladder outputs and feed back as logic inputs.
// [RQ12] All outputs register together per evaluation tick; inactive in reset.
//
// The address map and the APB register port are this design's own decisions.
`timescale 1ns/1ps
module rlm_top #(
   parameter bit HAS_DISPLAY = 1'b0
) (
   // Clock and reset
   input  wire logic                               clk,
   input  wire logic                               rstn,
   // APB register bus
   input  wire rlm_pkg::rlm_apb_req_s              apb_req,
   output      rlm_pkg::rlm_apb_rsp_s              apb_rsp,
   // Logic evaluation
   input  wire logic                               eval_tick,
   input  wire logic [rlm_pkg::N_PROG_RLY-1:0]     relay_lgc,
   input  wire logic [rlm_pkg::N_LAMP-1:0]         lamp_lgc,
   input  wire logic [rlm_pkg::N_FLAG-1:0]         flag_ladder,
   // Unit conditions
   input  wire rlm_pkg::rlm_cond_s                 cond,
   input  wire logic                               not_ready,
   input  wire logic                               controlled_breaker_open,
   input  wire logic                               controlled_breaker_close,
   // Relay coils
   output      logic                               relay_out_one,
   output      logic                               relay_out_two,
   output      logic                               relay_out_three,
   output      logic                               relay_out_four,
   output      logic                               relay_out_five,
   output      logic                               relay_out_six,
   // Lamps
   output      logic [rlm_pkg::N_LAMP-1:0]         lamp_out,
   // Flags and command variables for the logic engine
   output      logic [rlm_pkg::N_FLAG-1:0]         flag_q,
   output      logic [rlm_pkg::N_PROG_RLY-1:0]     cmd_var_q
);

   // ****************************************************************
   // Declarations
   // ****************************************************************
   localparam int unsigned RS_W = rlm_pkg::N_PROG_RLY * rlm_pkg::SEL_W;
   localparam int unsigned LS_W = rlm_pkg::N_LAMP * rlm_pkg::SEL_W;

   logic                            two_relay_q, two_relay_d;
   logic [RS_W-1:0]                 relay_sel_q, relay_sel_d;
   logic [LS_W-1:0]                 lamp_sel_q, lamp_sel_d;

   logic [rlm_pkg::N_RELAY-1:0]     relay_q, relay_d;
   logic [rlm_pkg::N_LAMP-1:0]      lamp_q, lamp_d;
   logic [rlm_pkg::N_FLAG-1:0]      flags_q, flags_d;
   logic [rlm_pkg::N_PROG_RLY-1:0]  cmdv_q, cmdv_d;

   logic [rlm_pkg::N_PROG_RLY-1:0]  relay_dflt;
   logic [rlm_pkg::N_PROG_RLY-1:0]  relay_res;
   logic [rlm_pkg::N_LAMP-1:0]      lamp_dflt;
   logic [rlm_pkg::N_LAMP-1:0]      lamp_res;

   logic                            wr_stb;
   logic                            hit;
   logic [rlm_pkg::DATA_W-1:0]      rd_data;
   logic [rlm_pkg::ADDR_W-1:0]      addr;
   logic [rlm_pkg::DATA_W-1:0]      wdata;

   assign addr  = apb_req.paddr;
   assign wdata = apb_req.pwdata;

   // ****************************************************************
   // Bus slave
   // ****************************************************************
   rlm_apb_slv u_apb (
      .clk     (clk),
      .rstn    (rstn),
      .apb_req (apb_req),
      .apb_rsp (apb_rsp),
      .rd_data (rd_data),
      .hit     (hit),
      .wr_stb  (wr_stb)
   );

   // Address decode; anything else answers with pslverr
   always_comb begin
      case (addr)
         rlm_pkg::OFS_CTRL,
         rlm_pkg::OFS_RELAY_SEL,
         rlm_pkg::OFS_LAMP_SEL,
         rlm_pkg::OFS_OUT_STAT,
         rlm_pkg::OFS_FLAGS,
         rlm_pkg::OFS_CMD_VAR:   hit = 1'b1;
         default:                hit = 1'b0;
      endcase
   end

   // Read data; unused upper bits read zero
   always_comb begin
      rd_data = '0;
      case (addr)
         rlm_pkg::OFS_CTRL:
            rd_data[rlm_pkg::CTRL_TWO_RELAY_POS] = two_relay_q;
         rlm_pkg::OFS_RELAY_SEL:
            rd_data[RS_W-1:0] = relay_sel_q;
         rlm_pkg::OFS_LAMP_SEL:
            rd_data[LS_W-1:0] = lamp_sel_q;
         rlm_pkg::OFS_OUT_STAT: begin
            rd_data[rlm_pkg::STAT_RELAY_POS +: rlm_pkg::N_RELAY] = relay_q;
            rd_data[rlm_pkg::STAT_LAMP_POS +: rlm_pkg::N_LAMP]   = lamp_q;
         end
         rlm_pkg::OFS_FLAGS:
            rd_data[rlm_pkg::N_FLAG-1:0] = flags_q;
         rlm_pkg::OFS_CMD_VAR:
            rd_data[rlm_pkg::N_PROG_RLY-1:0] = cmdv_q;
         default:
            rd_data = '0;
      endcase
   end

   // ****************************************************************
   // Configuration registers
   // ****************************************************************
   // Writes only; read-only offsets ignore the data
   always_comb begin
      two_relay_d = two_relay_q;
      relay_sel_d = relay_sel_q;
      lamp_sel_d  = lamp_sel_q;
      if (wr_stb) begin
         case (addr)
            rlm_pkg::OFS_CTRL:      two_relay_d = wdata[rlm_pkg::CTRL_TWO_RELAY_POS];
            rlm_pkg::OFS_RELAY_SEL: relay_sel_d = wdata[RS_W-1:0];
            rlm_pkg::OFS_LAMP_SEL:  lamp_sel_d  = wdata[LS_W-1:0];
            default: begin
               two_relay_d = two_relay_q;
            end
         endcase
      end
   end

   // Configuration flops; reset leaves every output on its default source
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         two_relay_q <= rlm_pkg::RST_CTRL[rlm_pkg::CTRL_TWO_RELAY_POS];
         relay_sel_q <= rlm_pkg::RST_RELAY_SEL[RS_W-1:0];
         lamp_sel_q  <= rlm_pkg::RST_LAMP_SEL[LS_W-1:0];
      end else begin
         two_relay_q <= two_relay_d;
         relay_sel_q <= relay_sel_d;
         lamp_sel_q  <= lamp_sel_d;
      end
   end

   // ****************************************************************
   // Default sources
   // ****************************************************************
   // Relay channel order: one, two, three, four, six
   assign relay_dflt[0] = 1'b0;                         // Relay one has no preset
   assign relay_dflt[1] = cond.central_alarm;           // RQ2
   assign relay_dflt[2] = cond.sys_b_not_ok;            // RQ3
   assign relay_dflt[3] = cond.sys_a_not_ok;            // RQ4
   assign relay_dflt[4] = cond.all_alarm_class;         // RQ5

   // Lamp presets
   assign lamp_dflt[0] = cond.sys_a_in_range;           // RQ7
   assign lamp_dflt[1] = cond.sys_b_in_range;           // RQ7
   assign lamp_dflt[2] = cond.breaker_closed;           // RQ8
   assign lamp_dflt[3] = cond.sync_active;              // RQ8
   assign lamp_dflt[4] = cond.close_cmd_active;         // RQ8
   assign lamp_dflt[5] = cond.open_failure;             // RQ9
   assign lamp_dflt[6] = cond.close_failure;            // RQ9
   assign lamp_dflt[7] = cond.member_missing;           // RQ10

   // ****************************************************************
   // Source selection
   // ****************************************************************
   rlm_src_mux #(.N(rlm_pkg::N_PROG_RLY)) u_relay_mux (
      .sel  (relay_sel_q),
      .dflt (relay_dflt),
      .lgc  (relay_lgc),
      .res  (relay_res)
   );

   rlm_src_mux #(.N(rlm_pkg::N_LAMP)) u_lamp_mux (
      .sel  (lamp_sel_q),
      .dflt (lamp_dflt),
      .lgc  (lamp_lgc),
      .res  (lamp_res)
   );

   // ****************************************************************
   // Output and flag update
   // ****************************************************************
   // Everything moves on the same tick so no coil or lamp lags another;
   // a selector written between ticks shows at the next tick only
   always_comb begin
      relay_d = relay_q;
      lamp_d  = lamp_q;
      flags_d = flags_q;
      cmdv_d  = cmdv_q;
      if (eval_tick) begin
         relay_d[0] = relay_res[0] | not_ready;                  // RQ1
         relay_d[1] = relay_res[1];                              // RQ2
         relay_d[2] = relay_res[2];                              // RQ3
         relay_d[3] = relay_res[3];                              // RQ4
         relay_d[4] = controlled_breaker_open;                   // RQ5
         relay_d[5] = two_relay_q ? controlled_breaker_close
                                  : relay_res[4];                // RQ5
         // Panel variants have no lamp drivers fitted
         lamp_d     = HAS_DISPLAY ? '0 : lamp_res;               // RQ6
         // Ladder results are held so the engine can reuse them next pass
         flags_d    = flag_ladder;                               // RQ11
         cmdv_d     = relay_res;                                 // RQ1
      end
   end

   // Output flops; coils drop while reset is held
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         relay_q <= '0;                                          // RQ12
         lamp_q  <= '0;                                          // RQ12
         flags_q <= '0;
         cmdv_q  <= '0;
      end else begin
         relay_q <= relay_d;                                     // RQ12
         lamp_q  <= lamp_d;                                      // RQ12
         flags_q <= flags_d;
         cmdv_q  <= cmdv_d;
      end
   end

   // ****************************************************************
   // Pins
   // ****************************************************************
   assign relay_out_one   = relay_q[0];
   assign relay_out_two   = relay_q[1];
   assign relay_out_three = relay_q[2];
   assign relay_out_four  = relay_q[3];
   assign relay_out_five  = relay_q[4];
   assign relay_out_six   = relay_q[5];
   assign lamp_out        = lamp_q;
   assign flag_q          = flags_q;
   assign cmd_var_q       = cmdv_q;

endmodule // rlm_top
